/* bl_pkg.sv */
`default_nettype none
package bl_pkg;
	// register map (word indexes on the plain port)
	localparam logic [3:0] ctrl_addr = 4'h0;
	localparam logic [3:0] bright_addr = 4'h1;
	localparam logic [3:0] ambient_addr = 4'h2;
	localparam logic [3:0] content_addr = 4'h3;
	localparam logic [3:0] pwm_cfg_addr = 4'h4;
	localparam logic [3:0] duty_rd_addr = 4'h5;
	localparam logic [3:0] light_rd_addr = 4'h6;
	localparam logic [3:0] cdim_rd_addr = 4'h7;
	localparam logic [3:0] sensed_rd_addr = 4'h8;
	localparam logic [3:0] status_addr = 4'h9;
	// control register bit positions
	localparam int gate_bit = 0;
	localparam int pwm_inv_bit = 1;
	localparam int on_inv_bit = 2;
	localparam int bright_ctrl_en_bit = 3;
	localparam int amb_en_bit = 4;
	localparam int auto_bit = 5;
	localparam int adc_en_bit = 6;
	localparam int dim_bit = 7;
	localparam int freq_bit = 8;
	localparam int content_adaptive_dim_on_bit = 9;
	localparam int sleep_out_bit = 10;
	localparam logic [10:0] ctrl_reset = 11'h000;
	localparam logic [7:0] pwm_div_reset = 8'h01;
	localparam logic [7:0] duty_full = 8'hFF;
	localparam logic [7:0] duty_zero = 8'h00;
	// timing
	localparam int clk_mhz = 100;
	localparam int fosc_hi_mhz = 10;
	localparam int fosc_lo_mhz = 5;
	localparam int div_hi = clk_mhz / fosc_hi_mhz;
	localparam int div_lo = clk_mhz / fosc_lo_mhz;
	localparam int first_avg_ms = 500;
	localparam int first_avg_cycles = first_avg_ms * 1000 * clk_mhz;
	localparam int frame_us = 16667;
	localparam int frame_cycles = frame_us * clk_mhz;
	localparam int mains_avg_len = 8;
	localparam logic [9:0] hyst_band = 10'h008;
	// one-hot dimming state
	typedef enum logic [2:0] {
		dim_idle = 3'b001,
		dim_up = 3'b010,
		dim_down = 3'b100
	} dim_state_type;
	// 8x8 scaled product, ff means full scale
	function automatic logic [7:0] scale8(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] p;
		p = 16'(a) * 16'(b) + 16'(a);
		return p[15:8];
	endfunction : scale8
endpackage : bl_pkg
`default_nettype wire

/* duty_if.sv */
`default_nettype none
interface duty_if;
	logic [7:0] duty;
	logic enable;
	modport src(output duty, output enable);
	modport sink(input duty, input enable);
endinterface : duty_if
`default_nettype wire

/* pwm_core.sv */
`default_nettype none
module pwm_core
	import bl_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// setup
	input wire logic freq_sel,
	input wire logic [7:0] pwm_divider,
	duty_if.sink dif,
	// waveform
	output logic wave
);
	logic [4:0] pre_cnt;
	logic [7:0] div_cnt;
	logic [7:0] phase;
	wire [4:0] pre_top = freq_sel ? 5'(div_hi - 1) : 5'(div_lo - 1);
	wire fosc_tick = (pre_cnt >= pre_top); // a frequency switch can leave the prescaler above the new top
	wire [7:0] div_top = (pwm_divider == duty_zero) ? duty_zero : pwm_divider - 8'h01;
	wire slot_tick = fosc_tick && (div_cnt >= div_top);
	// period = 256 slots of divider fosc ticks
	always_ff @(posedge core_clk)
	begin
		if (rst || fosc_tick)
			pre_cnt <= 5'h00;
		else
			pre_cnt <= pre_cnt + 5'h01;
		if (rst || slot_tick)
			div_cnt <= 8'h00;
		else if (fosc_tick)
			div_cnt <= div_cnt + 8'h01;
		if (rst)
			phase <= 8'h00;
		else if (slot_tick)
			phase <= phase + 8'h01;
		// ff duty keeps output high through the whole period
		wave <= !rst && dif.enable && ((dif.duty == duty_full) || (phase < dif.duty));
	end
endmodule : pwm_core
`default_nettype wire

/* ambient_filter.sv */
`default_nettype none
module ambient_filter
	import bl_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// source
	input wire logic run,
	input wire logic sample_stb,
	input wire logic [9:0] sample,
	// result
	output logic [7:0] level,
	output logic valid
);
	logic [12:0] acc;
	logic [2:0] cnt;
	logic [9:0] held;
	logic [31:0] wait_cnt;
	// the eighth sample must count before the window closes
	wire [12:0] sum = acc + 13'(sample);
	wire [9:0] avg = sum[12:3];
	wire [9:0] diff = (avg > held) ? avg - held : held - avg;
	// averaging 8 samples spread over a mains cycle cancels 50/60 hz ripple
	always_ff @(posedge core_clk)
	begin
		if (rst || !run)
		begin
			acc <= 13'h0000;
			cnt <= 3'h0;
			held <= 10'h000;
			valid <= 1'b0;
			wait_cnt <= 32'h00000000;
		end
		else
		begin
			if (!valid && wait_cnt < 32'(first_avg_cycles))
				wait_cnt <= wait_cnt + 32'h00000001;
			if (sample_stb)
			begin
				cnt <= cnt + 3'h1;
				acc <= (cnt == 3'h7) ? 13'h0000 : sum;
				if (cnt == 3'h7 && (diff > hyst_band || !valid))
					held <= avg;
				if (cnt == 3'h7 || wait_cnt + 32'h00000001 >= 32'(first_avg_cycles))
					valid <= 1'b1;
			end
		end
	end
	assign level = held[9:2];
endmodule : ambient_filter
`default_nettype wire

/* backlight_ctrl.sv */
`default_nettype none
// Functional notes
// - brightness equals ambient-or-manual ratio times content ratio
// - gate low stops pwm, pin at inversion level
// - gate high drives waveform, optionally inverted
// - on pin follows gate and own polarity
// - enable clear dims down, readback 00h
// - enable set reports combined brightness, backlight on
// - ambient enable starts sampling, first value 500ms
// - converter runs when all three bits and sleep out set
// - otherwise converter off; host ambient value used in ambient mode, else manual value
// - auto select clear means manual brightness
// - content path off reads FFh
// - auto plus ambient uses ambient function
// - duty from combined result, on pin on/off
// - mains flicker removal and hysteresis on ambient
// - sensed ambient value readable by host
// - one dim enable bit for both paths
// - pwm clock 5/10 MHz over 256 times divider
module backlight_ctrl
	import bl_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// sensor converter
	input wire logic adc_stb,
	input wire logic [9:0] adc_data,
	output logic adc_run,
	// pins
	output logic backlight_pwm_out,
	output logic backlight_on_out
);
	logic [10:0] ctrl;
	logic [7:0] brightness_value;
	logic [15:0] ambient_light_value;
	logic [7:0] content_ratio;
	logic [7:0] pwm_divider;
	logic [7:0] cur_duty;
	logic [31:0] frame_cnt;
	logic host_amb_stb;
	dim_state_type dim_state;
	logic [7:0] sensed_level;
	logic sensed_valid;
	logic wave;
	duty_if dif();

	// control bit decode
	wire backlight_gate = ctrl[gate_bit];
	wire pwm_pin_invert = ctrl[pwm_inv_bit];
	wire on_pin_invert = ctrl[on_inv_bit];
	wire bright_ctrl_en = ctrl[bright_ctrl_en_bit];
	wire amb_en = ctrl[amb_en_bit];
	wire auto_bright_sel = ctrl[auto_bit];
	wire adc_en = ctrl[adc_en_bit];
	wire dim_enable = ctrl[dim_bit];
	wire pwm_src_freq_sel = ctrl[freq_bit];
	wire content_on = ctrl[content_adaptive_dim_on_bit];
	wire sleep_out = ctrl[sleep_out_bit];

	// source selection for the ambient ratio
	wire ambient_mode = sleep_out && amb_en && auto_bright_sel;
	wire use_adc = ambient_mode && adc_en;
	wire [7:0] amb_ratio = use_adc ? sensed_level : ambient_light_value[15:8];
	wire [7:0] light_duty_read = ambient_mode ? amb_ratio : brightness_value;
	wire [7:0] content_duty_read = content_on ? content_ratio : duty_full;
	wire [7:0] combined = scale8(light_duty_read, content_duty_read);
	wire [7:0] target = (bright_ctrl_en && sleep_out) ? combined : duty_zero;
	wire frame_tick = (frame_cnt == 32'(frame_cycles - 1));
	wire host_src = use_adc ? adc_stb : host_amb_stb;
	wire [9:0] filt_in = use_adc ? adc_data : ambient_light_value[15:6];

	// frame pacing
	always_ff @(posedge core_clk)
	begin
		if (rst || frame_tick)
			frame_cnt <= 32'h00000000;
		else
			frame_cnt <= frame_cnt + 32'h00000001;
	end

	// register writes
	always_ff @(posedge core_clk)
	begin
		host_amb_stb <= 1'b0;
		if (rst)
		begin
			ctrl <= ctrl_reset;
			brightness_value <= duty_zero;
			ambient_light_value <= 16'h0000;
			content_ratio <= duty_full;
			pwm_divider <= pwm_div_reset;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				ctrl_addr: ctrl <= reg_wdata[10:0];
				bright_addr: brightness_value <= reg_wdata[7:0];
				ambient_addr:
				begin
					ambient_light_value <= reg_wdata;
					host_amb_stb <= 1'b1;
				end
				content_addr: content_ratio <= reg_wdata[7:0];
				pwm_cfg_addr: pwm_divider <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	// dimming: one step per frame when enabled, jump when disabled
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cur_duty <= duty_zero;
			dim_state <= dim_idle;
		end
		else if (!dim_enable)
		begin
			cur_duty <= target;
			dim_state <= dim_idle;
		end
		else if (frame_tick)
		begin
			case (dim_state)
				dim_idle:
					dim_state <= (target > cur_duty) ? dim_up : (target < cur_duty) ? dim_down : dim_idle;
				dim_up:
				begin
					cur_duty <= cur_duty + 8'h01;
					if (cur_duty + 8'h01 >= target)
						dim_state <= dim_idle;
				end
				dim_down:
				begin
					cur_duty <= cur_duty - 8'h01;
					if (cur_duty - 8'h01 <= target)
						dim_state <= dim_idle;
				end
				default: dim_state <= dim_idle;
			endcase
		end
	end

	assign dif.duty = cur_duty;
	assign dif.enable = backlight_gate;

	pwm_core u_pwm (
		.core_clk(core_clk),
		.rst(rst),
		.freq_sel(pwm_src_freq_sel),
		.pwm_divider(pwm_divider),
		.dif(dif),
		.wave(wave)
	);

	ambient_filter u_amb (
		.core_clk(core_clk),
		.rst(rst),
		.run(sleep_out && amb_en),
		.sample_stb(host_src),
		.sample(filt_in),
		.level(sensed_level),
		.valid(sensed_valid)
	);

	// pins: gate low parks pin at polarity level
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			backlight_pwm_out <= 1'b0;
			backlight_on_out <= 1'b0;
			adc_run <= 1'b0;
		end
		else
		begin
			backlight_pwm_out <= (backlight_gate && wave) ^ pwm_pin_invert;
			backlight_on_out <= backlight_gate ^ on_pin_invert;
			adc_run <= use_adc;
		end
	end

	// read data one cycle after strobe
	always_ff @(posedge core_clk)
	begin
		if (rst || !reg_rd)
			reg_rdata <= 16'h0000;
		else
		begin
			case (reg_addr)
				ctrl_addr: reg_rdata <= {5'h00, ctrl};
				bright_addr: reg_rdata <= {8'h00, brightness_value};
				ambient_addr: reg_rdata <= ambient_light_value;
				content_addr: reg_rdata <= {8'h00, content_ratio};
				pwm_cfg_addr: reg_rdata <= {8'h00, pwm_divider};
				duty_rd_addr: reg_rdata <= {8'h00, cur_duty};
				light_rd_addr: reg_rdata <= {8'h00, light_duty_read};
				cdim_rd_addr: reg_rdata <= {8'h00, content_duty_read};
				sensed_rd_addr: reg_rdata <= {7'h00, sensed_valid, sensed_level};
				status_addr: reg_rdata <= {13'h0000, dim_state};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule : backlight_ctrl
`default_nettype wire

/* bl_chk_sva.sv */
`default_nettype none
module bl_chk
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// sensor and pins
	input wire logic adc_stb,
	input wire logic [9:0] adc_data,
	input wire logic adc_run,
	input wire logic backlight_pwm_out,
	input wire logic backlight_on_out
);
	import bl_pkg::*;
	logic [10:0] ctrl;
	logic [2:0] settle;
	wire ctrl_wr = reg_wr && reg_addr == ctrl_addr;
	wire quiet = settle == 3'h7;
	wire both_auto = ctrl[amb_en_bit] && ctrl[auto_bit];
	// shadow control; settle gives pipelined outputs time to catch up after a write
	always_ff @(posedge core_clk)
	begin
		if (rst || ctrl_wr)
			settle <= 3'h0;
		else if (!quiet)
			settle <= settle + 3'h1;
		if (rst)
			ctrl <= ctrl_reset;
		else if (ctrl_wr)
			ctrl <= reg_wdata[10:0];
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	property p_pwm_gated;
		quiet && !ctrl[gate_bit] |-> backlight_pwm_out == ctrl[pwm_inv_bit];
	endproperty
	a_pwm_gated: assert property (p_pwm_gated) else $error("pwm pin not at idle level");
	property p_on_pin;
		quiet |-> backlight_on_out == (ctrl[gate_bit] ^ ctrl[on_inv_bit]);
	endproperty
	a_on_pin: assert property (p_on_pin) else $error("on pin level wrong");
	property p_adc_run;
		quiet && ctrl[sleep_out_bit] && both_auto && ctrl[adc_en_bit] |-> adc_run [*2];
	endproperty
	a_adc_run: assert property (p_adc_run) else $error("converter not running");
	property p_adc_off;
		quiet && !both_auto |-> !adc_run;
	endproperty
	a_adc_off: assert property (p_adc_off) else $error("converter running");
	property p_content_ff;
		quiet && !ctrl[content_adaptive_dim_on_bit] && reg_rd && reg_addr == cdim_rd_addr |=> reg_rdata == 16'h00FF;
	endproperty
	a_content_ff: assert property (p_content_ff) else $error("content duty not full");
	property p_off_zero;
		quiet && !ctrl[bright_ctrl_en_bit] && !ctrl[dim_bit] && reg_rd && reg_addr == duty_rd_addr |=> reg_rdata == 16'h0000;
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("duty not zero when disabled");
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
	property p_unmapped;
		reg_rd && reg_addr > status_addr |=> reg_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	c_gate_on: cover property (quiet && ctrl[gate_bit] && backlight_pwm_out);
	c_sample: cover property (adc_run && adc_stb);
	c_unmapped: cover property (reg_rd && reg_addr > status_addr);
endmodule : bl_chk
`default_nettype wire

/* amb_sensor_model.sv */
`default_nettype none
module amb_sensor_model
(
	// clock and control
	input wire logic core_clk,
	input wire logic adc_run,
	input wire logic [9:0] level,
	// converter output
	output logic adc_stb,
	output logic [9:0] adc_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt = 6'h00;
	initial adc_stb = 1'b0;
	initial adc_data = 10'h155;
	// one sample per 64 cycles; idle data toggles so a stale value never looks valid
	always @(posedge core_clk)
	begin
		cnt <= adc_run ? cnt + 6'h01 : 6'h00;
		adc_stb <= adc_run && cnt == 6'h3F;
		adc_data <= (adc_run && cnt == 6'h3F) ? level : ~adc_data;
	end
endmodule : amb_sensor_model
`default_nettype wire

/* dynamic_backlight_pwm_control_tb_top.sv */
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module dynamic_backlight_pwm_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import bl_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, adc_stb, adc_run, pwm, on;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, got;
	logic [9:0] adc_data;
	logic [7:0] av [3] = '{8'h80, 8'hB3, 8'hFF};
	logic [7:0] bv [3] = '{8'h80, 8'h00, 8'hFF};
	int n_mismatch = 0, check_count = 0;
	always #5 core_clk = ~core_clk;
	backlight_ctrl dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_stb(adc_stb), .adc_data(adc_data),
		.adc_run(adc_run), .backlight_pwm_out(pwm), .backlight_on_out(on));
	amb_sensor_model sensor (.core_clk(core_clk), .adc_run(adc_run), .level(10'h2A8), .adc_stb(adc_stb),
		.adc_data(adc_data));
	function automatic logic [7:0] prod(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] p;
		p = {8'h00, a} * {8'h00, b} + {8'h00, a};
		return p[15:8];
	endfunction : prod
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		// one idle edge lets the write reach derived state before the next request
		@(posedge core_clk);
	endtask : wr
	// empty name means a poll read with no comparison
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		got = reg_rdata;
		if (nm != "")
			`CHK(nm, e, got)
		@(posedge core_clk);
	endtask : rd
	task automatic pins(input logic ep, input logic eo, input int n);
		repeat (n) @(posedge core_clk);
		#1;
		`CHK("pwm_pin", ep, pwm)
		`CHK("on_pin", eo, on)
		@(posedge core_clk);
	endtask : pins
	task automatic period(input int e);
		realtime t0;
		// a duty jump can raise the pin mid-period, so time from the second rise
		@(posedge pwm);
		@(posedge pwm);
		t0 = $realtime;
		@(posedge pwm);
		`CHK("pwm_period", e, int'(($realtime - t0) / 10.0))
		@(posedge core_clk);
	endtask : period
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rd(ctrl_addr, 16'h0000, "ctrl");
		rd(pwm_cfg_addr, {8'h00, pwm_div_reset}, "divider");
		rd(cdim_rd_addr, 16'h00FF, "content_duty");
		wr(4'hC, 16'hFFFF);
		rd(4'hF, 16'h0000, "unmapped");
		rd(ctrl_addr, 16'h0000, "ctrl");
		// full duty keeps the waveform high, so the pin shows gate and polarity alone
		wr(bright_addr, 16'h00FF);
		for (int i = 0; i < 8; i++)
		begin
			wr(ctrl_addr, 16'h0508 | 16'(i));
			pins(i[0] ^ i[1], i[0] ^ i[2], 8);
		end
		rd(duty_rd_addr, 16'h00FF, "duty");
		wr(ctrl_addr, 16'h0709);
		for (int k = 0; k < 3; k++)
		begin
			wr(bright_addr, {8'h00, av[k]});
			wr(content_addr, {8'h00, bv[k]});
			repeat (8) @(posedge core_clk);
			rd(duty_rd_addr, {8'h00, prod(av[k], bv[k])}, "duty");
			rd(light_rd_addr, {8'h00, av[k]}, "light_duty");
		end
		// host supplies the ambient value while the converter stays off
		wr(ctrl_addr, 16'h0539);
		wr(ambient_addr, 16'hA55A);
		repeat (8) @(posedge core_clk);
		rd(light_rd_addr, 16'h00A5, "light_duty");
		rd(duty_rd_addr, 16'h00A5, "duty");
		`CHK("adc_run", 1'b0, adc_run)
		// drop ambient enable first so the averager restarts clean on converter samples
		wr(ctrl_addr, 16'h0549);
		wr(ctrl_addr, 16'h0579);
		got = 16'h0000;
		for (int n = 0; n < 400 && got[15:8] === 8'h00; n++)
			rd(sensed_rd_addr, 16'h0000, "");
		`CHK("adc_run", 1'b1, adc_run)
		`CHK("sensed", 8'hAA, got[7:0])
		rd(light_rd_addr, 16'h00AA, "light_duty");
		wr(ctrl_addr, 16'h0401);
		rd(duty_rd_addr, 16'h0000, "duty");
		pins(1'b0, 1'b1, 6000);
		wr(ctrl_addr, 16'h0489);
		repeat (8) @(posedge core_clk);
		// dimming holds the duty until the next frame boundary, so nothing has moved yet
		rd(duty_rd_addr, 16'h0000, "duty");
		rd(status_addr, 16'h0001, "dim_state");
		wr(bright_addr, 16'h0080);
		for (int f = 0; f < 3; f++)
		begin
			wr(pwm_cfg_addr, (f == 1) ? 16'h0002 : 16'h0001);
			wr(ctrl_addr, (f == 2) ? 16'h0409 : 16'h0509);
			period(256 * ((f == 1) ? 2 : 1) * ((f == 2) ? div_lo : div_hi));
		end
		finish_test();
	end
	initial
	begin
		#(1_000_000);
		n_mismatch++;
		finish_test();
	end
endmodule : dynamic_backlight_pwm_control_tb_top
bind backlight_ctrl bl_chk chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_stb(adc_stb), .adc_data(adc_data),
	.adc_run(adc_run), .backlight_pwm_out(backlight_pwm_out), .backlight_on_out(backlight_on_out));
`undef CHK
`default_nettype wire
